// >>> hw/ccm_pkg.sv
package ccm_pkg;
   // Register byte addresses on APB
   localparam logic [11:0] ADDR_MODE    = 12'h000;
   localparam logic [11:0] ADDR_CMP_LO  = 12'h004;
   localparam logic [11:0] ADDR_CMP_HI  = 12'h008;
   localparam logic [11:0] ADDR_CTRL    = 12'h00c;
   localparam logic [11:0] ADDR_CLKCTL  = 12'h010;
   localparam logic [11:0] ADDR_COUNTER = 12'h014;
   localparam logic [11:0] ADDR_IRQ_ST  = 12'h018;
   localparam logic [11:0] ADDR_IRQ_MSK = 12'h01c;
   // Module mode register fields
   localparam int MODE_IRQ_EN_BIT = 0;
   localparam int MODE_MATCH_BIT  = 3;
   localparam int MODE_CMP_EN_BIT = 6;
   // Array control register fields
   localparam int CTRL_FLAG_BIT = 0;
   localparam int CTRL_RUN_BIT  = 6;
   // Clock control fields
   localparam int CLK_X2_BIT = 0;
   // Oscillator clocks per machine cycle
   localparam int CLKS_STD = 12;
   localparam int CLKS_X2  = 6;
   localparam int DIV_W    = 4;
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage

// >>> hw/ccm_tick_div.sv
`timescale 1ns/10ps
`default_nettype none
module ccm_tick_div (
   input  wire logic pclk,
   input  wire logic presetn,
   ccm_tick_if.src   tk
);
   logic [ccm_pkg::DIV_W-1:0] cnt_ff;
   logic [ccm_pkg::DIV_W-1:0] last_cnt;

   // Machine-cycle length from the speed select
   assign last_cnt = tk.double_speed_select ?
                     ccm_pkg::DIV_W'(ccm_pkg::CLKS_X2 - 1) :
                     ccm_pkg::DIV_W'(ccm_pkg::CLKS_STD - 1);
   assign tk.tick  = (cnt_ff >= last_cnt);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
      end else if (tk.tick) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tk.tick && $stable(tk.double_speed_select) && tk.double_speed_select)
      |=> (!tk.tick [*5] ##1 tk.tick) or
          (##[0:5] !tk.double_speed_select))
      else $error("double speed tick period not six clocks");
endmodule
`default_nettype wire

// >>> hw/ccm_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ccm_tick_if;
   logic        double_speed_select;
   logic        tick;
   modport src (input double_speed_select, output tick);
   modport dst (output double_speed_select, input tick);
endinterface
`default_nettype wire

// >>> hw/ccm_top.sv
// Summary of operation
// - Compare mode needs compare and match enables
// - Interrupt when flag and irq enable set
// - Low compare byte write clears compare enable
// - High compare byte write sets compare enable
// - Compare enable stays directly readable and writable
// - Speed select: 12 or 6 clocks
// - Reset selects standard speed
// - Double speed halves peripheral time reference
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ccm_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             match_irq_req
);
   logic [7:0]  mode_ff;
   logic [7:0]  cmp_lo_ff;
   logic [7:0]  cmp_hi_ff;
   logic        flag_ff;
   logic        run_ff;
   logic        x2_ff;
   logic [15:0] counter_ff;
   logic        irq_st_ff;
   logic        irq_msk_ff;
   logic        nxt_flag;
   logic        wr_en;
   logic        rd_en;
   logic        hit;
   logic        match_ev;
   logic        mapped;
   logic        tick;

   ccm_tick_if tk_if ();

   assign tk_if.double_speed_select = x2_ff;
   assign tick = tk_if.tick;

   ccm_tick_div u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .tk      (tk_if.src)
   );

   function automatic logic addr_is(input logic [11:0] a,
                                    input logic [11:0] r);
      return a == r;
   endfunction

   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !pwrite;
   assign pready  = 1'b1;
   assign mapped  = addr_is(paddr, ccm_pkg::ADDR_MODE) ||
                    addr_is(paddr, ccm_pkg::ADDR_CMP_LO) ||
                    addr_is(paddr, ccm_pkg::ADDR_CMP_HI) ||
                    addr_is(paddr, ccm_pkg::ADDR_CTRL) ||
                    addr_is(paddr, ccm_pkg::ADDR_CLKCTL) ||
                    addr_is(paddr, ccm_pkg::ADDR_COUNTER) ||
                    addr_is(paddr, ccm_pkg::ADDR_IRQ_ST) ||
                    addr_is(paddr, ccm_pkg::ADDR_IRQ_MSK);
   assign pslverr = psel && penable && !mapped;

   // Compare hit on full 16-bit value, armed by both enables
   assign hit = (counter_ff == {cmp_hi_ff, cmp_lo_ff}) &&
                mode_ff[ccm_pkg::MODE_CMP_EN_BIT] &&
                mode_ff[ccm_pkg::MODE_MATCH_BIT];
   assign match_ev = hit && tick && run_ff;

   // Array counter advances once per machine cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_ff <= ccm_pkg::RESET_WORD;
      end else if (wr_en && addr_is(paddr, ccm_pkg::ADDR_COUNTER)) begin
         counter_ff <= pwdata[15:0];
      end else if (run_ff && tick) begin
         counter_ff <= counter_ff + 16'h0001;
      end
   end

   // Mode register with compare-enable side effects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= ccm_pkg::RESET_BYTE;
      end else if (wr_en && addr_is(paddr, ccm_pkg::ADDR_MODE)) begin
         mode_ff <= pwdata[7:0];
      end else if (wr_en && addr_is(paddr, ccm_pkg::ADDR_CMP_LO)) begin
         mode_ff[ccm_pkg::MODE_CMP_EN_BIT] <= 1'b0;
      end else if (wr_en && addr_is(paddr, ccm_pkg::ADDR_CMP_HI)) begin
         mode_ff[ccm_pkg::MODE_CMP_EN_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_lo_ff <= ccm_pkg::RESET_BYTE;
         cmp_hi_ff <= ccm_pkg::RESET_BYTE;
      end else begin
         if (wr_en && addr_is(paddr, ccm_pkg::ADDR_CMP_LO)) begin
            cmp_lo_ff <= pwdata[7:0];
         end
         if (wr_en && addr_is(paddr, ccm_pkg::ADDR_CMP_HI)) begin
            cmp_hi_ff <= pwdata[7:0];
         end
      end
   end

   // Match flag: set wins over software write of zero
   always_comb begin
      nxt_flag = flag_ff;
      if (wr_en && addr_is(paddr, ccm_pkg::ADDR_CTRL)) begin
         nxt_flag = pwdata[ccm_pkg::CTRL_FLAG_BIT];
      end
      if (match_ev) begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_ff <= 1'b0;
         run_ff  <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         if (wr_en && addr_is(paddr, ccm_pkg::ADDR_CTRL)) begin
            run_ff <= pwdata[ccm_pkg::CTRL_RUN_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x2_ff <= 1'b0;
      end else if (wr_en && addr_is(paddr, ccm_pkg::ADDR_CLKCTL)) begin
         x2_ff <= pwdata[ccm_pkg::CLK_X2_BIT];
      end
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_ff  <= 1'b0;
         irq_msk_ff <= 1'b0;
      end else begin
         if (match_ev) begin
            irq_st_ff <= 1'b1;
         end else if (wr_en && addr_is(paddr, ccm_pkg::ADDR_IRQ_ST) &&
                      pwdata[0]) begin
            irq_st_ff <= 1'b0;
         end
         if (wr_en && addr_is(paddr, ccm_pkg::ADDR_IRQ_MSK)) begin
            irq_msk_ff <= pwdata[0];
         end
      end
   end

   assign match_irq_req = flag_ff && mode_ff[ccm_pkg::MODE_IRQ_EN_BIT];
   assign irq = irq_st_ff && irq_msk_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en && !penable) begin
         unique case (1'b1)
            addr_is(paddr, ccm_pkg::ADDR_MODE):
               prdata <= {24'h000000, mode_ff};
            addr_is(paddr, ccm_pkg::ADDR_CMP_LO):
               prdata <= {24'h000000, cmp_lo_ff};
            addr_is(paddr, ccm_pkg::ADDR_CMP_HI):
               prdata <= {24'h000000, cmp_hi_ff};
            addr_is(paddr, ccm_pkg::ADDR_CTRL):
               prdata <= {25'h0000000, run_ff, 5'h00, flag_ff};
            addr_is(paddr, ccm_pkg::ADDR_CLKCTL):
               prdata <= {31'h00000000, x2_ff};
            addr_is(paddr, ccm_pkg::ADDR_COUNTER):
               prdata <= {16'h0000, counter_ff};
            addr_is(paddr, ccm_pkg::ADDR_IRQ_ST):
               prdata <= {31'h00000000, irq_st_ff};
            addr_is(paddr, ccm_pkg::ADDR_IRQ_MSK):
               prdata <= {31'h00000000, irq_msk_ff};
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   sequence lo_write_s;
      wr_en && addr_is(paddr, ccm_pkg::ADDR_CMP_LO);
   endsequence

   sequence hi_write_s;
      wr_en && addr_is(paddr, ccm_pkg::ADDR_CMP_HI);
   endsequence

   lo_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
      lo_write_s |=> !mode_ff[ccm_pkg::MODE_CMP_EN_BIT])
      else $error("low byte write left compare enable set");

   hi_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      hi_write_s |=> mode_ff[ccm_pkg::MODE_CMP_EN_BIT])
      else $error("high byte write did not set compare enable");

   mode_direct_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && addr_is(paddr, ccm_pkg::ADDR_MODE)) |=>
      mode_ff[ccm_pkg::MODE_CMP_EN_BIT] ==
      $past(pwdata[ccm_pkg::MODE_CMP_EN_BIT]))
      else $error("mode write did not store compare enable");

   match_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && run_ff && mode_ff[ccm_pkg::MODE_CMP_EN_BIT] &&
       mode_ff[ccm_pkg::MODE_MATCH_BIT] &&
       counter_ff == {cmp_hi_ff, cmp_lo_ff}) |=> flag_ff)
      else $error("match did not set flag");

   no_match_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_ff[ccm_pkg::MODE_MATCH_BIT] && !flag_ff &&
       !(wr_en && addr_is(paddr, ccm_pkg::ADDR_CTRL))) |=> !flag_ff)
      else $error("flag set without match enable");

   irq_req_a: assert property (@(posedge pclk) disable iff (!presetn)
      match_irq_req == (flag_ff && mode_ff[ccm_pkg::MODE_IRQ_EN_BIT]))
      else $error("interrupt request mismatch");

   std_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !x2_ff && $stable(x2_ff)) |=>
      (!tick [*8] ##1 !tick [*3] ##1 tick) or
      (##[0:11] x2_ff))
      else $error("standard tick period not twelve clocks");

   x2_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && addr_is(paddr, ccm_pkg::ADDR_CLKCTL)) |=>
      x2_ff == $past(pwdata[ccm_pkg::CLK_X2_BIT]))
      else $error("speed select not stored");

   reset_std_a: assert property (@(posedge pclk)
      $rose(presetn) |-> !x2_ff)
      else $error("speed select not cleared by reset");
endmodule
`default_nettype wire

// >>> verification/counter_compare_module_test.sv
`timescale 1ns/10ps
`default_nettype none
module counter_compare_module_test;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        match_irq_req;
   logic [32:0] exp_q[$];
   logic [32:0] note;
   logic [15:0] seed;
   int          failures;
   int          n_compared;
   int          t;

   ccm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .match_irq_req(match_irq_req));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Bit 32 of a note is the expected error flag
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
      exp_q.push_back(e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, {1'b0, e});
   endtask

   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         note = exp_q.pop_front();
         chk({31'h0, pslverr}, {31'h0, note[32]});
         if (pwrite === 1'b0) chk(prdata, note[31:0]);
      end
   end

   // Counter starts c, compare c+4: five ticks to the match
   task automatic run_match(input logic x2, input logic [31:0] mode,
                            input logic hit);
      logic [15:0] c;
      logic [15:0] cv;
      seed = lfsr(seed);
      c = seed | 16'h0001;
      cv = c + 16'h0004;
      wr(ccm_pkg::ADDR_CLKCTL, {31'h0, x2});
      wr(ccm_pkg::ADDR_CTRL, 32'h0);
      wr(ccm_pkg::ADDR_COUNTER, {16'h0, c});
      wr(ccm_pkg::ADDR_CMP_LO, {24'h0, cv[7:0]});
      wr(ccm_pkg::ADDR_CMP_HI, {24'h0, cv[15:8]});
      wr(ccm_pkg::ADDR_MODE, mode);
      wr(ccm_pkg::ADDR_CTRL, 32'h40);
      t = 0;
      // Sample on the falling edge, away from register updates
      while (match_irq_req !== 1'b1 && t < (x2 ? 36 : 72)) begin
         @(negedge pclk);
         t++;
      end
      chk({31'h0, match_irq_req}, {31'h0, hit});
      if (hit) chk({31'h0, t > (x2 ? 24 : 48)}, 32'h1);
      @(posedge pclk);
      rd(ccm_pkg::ADDR_CTRL, {25'h0, 1'b1, 5'h0, hit});
   endtask

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      seed = 16'h0009;
      failures = 0;
      n_compared = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({30'h0, irq, match_irq_req}, 32'h0);
      rd(ccm_pkg::ADDR_CLKCTL, 32'h0);
      rd(ccm_pkg::ADDR_MODE, 32'h0);
      wr(ccm_pkg::ADDR_MODE, 32'h49);
      rd(ccm_pkg::ADDR_MODE, 32'h49);
      wr(ccm_pkg::ADDR_CMP_LO, 32'h12);
      rd(ccm_pkg::ADDR_MODE, 32'h09);
      wr(ccm_pkg::ADDR_CMP_HI, 32'h34);
      rd(ccm_pkg::ADDR_MODE, 32'h49);
      wr(ccm_pkg::ADDR_MODE, 32'h09);
      rd(ccm_pkg::ADDR_MODE, 32'h09);
      run_match(1'b0, 32'h49, 1'b1);
      wr(ccm_pkg::ADDR_MODE, 32'h48);
      chk({31'h0, match_irq_req}, 32'h0);
      wr(ccm_pkg::ADDR_IRQ_MSK, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(ccm_pkg::ADDR_IRQ_MSK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(ccm_pkg::ADDR_IRQ_MSK, 32'h1);
      wr(ccm_pkg::ADDR_IRQ_ST, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rd(ccm_pkg::ADDR_IRQ_ST, 32'h0);
      run_match(1'b1, 32'h49, 1'b1);
      run_match(1'b0, 32'h41, 1'b0);
      run_match(1'b1, 32'h09, 1'b0);
      xfer(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
      xfer(1'b1, 12'h024, 32'h5, {1'b1, 32'h0});
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      stop_test();
   end
endmodule
`default_nettype wire
